// >>> rtl/cgms_bank_out.sv
`timescale 1ns/100ps
`default_nettype none
module cgms_bank_out
    import cgms_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // pin-latched settings
    input  wire logic [3:0]            pin_freq,
    input  wire logic                  pin_lvcmos,
    // register settings
    input  wire logic [CGMS_CFG_W-1:0] reg_cfg,
    input  wire logic                  programmed,
    // sequencing
    input  wire logic                  released,
    input  wire logic                  pll_locked,
    input  wire logic                  powered_down,
    // bank drive
    output logic                       active_reg,
    output logic [3:0]                 freq_reg,
    output logic                       lvcmos_reg
);

    logic run_ok;

    // unprogrammed banks fall back to the pin latch
    always_comb begin
        if (programmed) begin
            run_ok = reg_cfg[CGMS_CFG_EN_BIT] && !reg_cfg[CGMS_CFG_BLKPD_BIT];
        end else begin
            run_ok = 1'b1;
        end
    end

    // release is gated by pll lock, so lost lock parks the bank static
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= released && pll_locked && !powered_down && run_ok;
        end
    end

    // settings follow the register map once written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            freq_reg   <= 4'h0;
            lvcmos_reg <= 1'b0;
        end else if (programmed) begin
            freq_reg   <= reg_cfg[CGMS_CFG_FREQ_LSB +: 4];
            lvcmos_reg <= reg_cfg[CGMS_CFG_LVCMOS_BIT];
        end else begin
            freq_reg   <= pin_freq;
            lvcmos_reg <= pin_lvcmos;
        end
    end

    property p_unlocked_static;
        @(posedge clk) disable iff (!rst_n)
        !pll_locked |=> !active_reg;
    endproperty
    a_unlocked_static: assert property (p_unlocked_static)
        else $error("bank active without pll lock");

endmodule
`default_nettype wire

// >>> rtl/cgms_pkg.sv
package cgms_pkg;

    // apb register byte offsets
    localparam logic [7:0] CGMS_CTRL_OFS     = 8'h00;
    localparam logic [7:0] CGMS_STATUS_OFS   = 8'h04;
    localparam logic [7:0] CGMS_BANK_CFG_OFS = 8'h08;  // banks 1..4 at 0x08, 0x0C, 0x10, 0x14
    localparam logic [7:0] CGMS_ADDR_LAST    = 8'h14;

    // control register fields
    localparam int CGMS_CTRL_LOADED_BIT = 0;  // register files loaded, release held banks
    localparam int CGMS_CTRL_BYPASS_BIT = 1;  // reference bypass to bank 1
    localparam int CGMS_CTRL_PWRDN_BIT  = 2;  // whole-device power-down
    localparam logic [2:0] CGMS_CTRL_RESET = 3'h0;

    // bank configuration fields
    localparam int CGMS_CFG_W          = 7;
    localparam int CGMS_CFG_FREQ_LSB   = 0;   // 4-bit frequency code
    localparam int CGMS_CFG_LVCMOS_BIT = 4;
    localparam int CGMS_CFG_EN_BIT     = 5;
    localparam int CGMS_CFG_BLKPD_BIT  = 6;
    localparam logic [CGMS_CFG_W-1:0] CGMS_CFG_RESET = 7'h00;

    // status register fields
    localparam int CGMS_ST_STATE_LSB  = 0;    // 3-bit sequencer state
    localparam int CGMS_ST_SERIAL_BIT = 3;
    localparam int CGMS_ST_LOCK_BIT   = 4;
    localparam int CGMS_ST_ADDR_LSB   = 8;    // 7-bit slave address
    localparam int CGMS_ST_PROG_LSB   = 16;   // 4-bit programmed mask
    localparam int CGMS_ST_REL_LSB    = 20;   // 4-bit released mask

    // tri-level pin codes
    localparam logic [1:0] CGMS_PIN_LOW  = 2'h0;
    localparam logic [1:0] CGMS_PIN_MID  = 2'h1;
    localparam logic [1:0] CGMS_PIN_HIGH = 2'h2;

    // serial-bus slave address base; value arbitrary
    localparam logic [6:0] CGMS_SLAVE_BASE = 7'h60;

    localparam int CGMS_NBANK = 4;

    typedef enum logic [2:0] {
        ST_LATCH    = 3'b000,
        ST_PIN_WAIT = 3'b001,
        ST_PIN_RUN  = 3'b010,
        ST_PWRDN    = 3'b011,
        ST_MIX_WAIT = 3'b100,
        ST_SERIAL   = 3'b101
    } cgms_state_t;

endpackage

// >>> rtl/cgms_sequencer.sv
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cgms_sequencer
    import cgms_pkg::*;
(
    // clock and power-up reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // serial line levels and mode pins
    input  wire logic        serial_data_level,
    input  wire logic        serial_clock_powerdown,
    input  wire logic        mixed_mode_select,
    // tri-level frequency select pins
    input  wire logic [1:0]  bank1_freq_select,
    input  wire logic [1:0]  bank2_freq_select,
    input  wire logic [1:0]  bank3_freq_select,
    input  wire logic [1:0]  output_bank_4_select_a,
    input  wire logic [1:0]  output_bank_4_select_b,
    // pll
    input  wire logic        pll_locked,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // output bank drive
    output logic [3:0]       bank_active,
    output logic [15:0]      bank_freq_code,
    output logic [3:0]       bank_lvcmos,
    output logic             ref_bypass,
    output logic             device_powered_down,
    output logic             serial_mode_active,
    output logic [6:0]       slave_address
);

    cgms_state_t             state_reg;
    cgms_state_t             state_next;
    logic [3:0]              pin_freq_reg [CGMS_NBANK];
    logic [3:0]              pin_lvcmos_reg;
    logic [CGMS_CFG_W-1:0]   cfg_reg [CGMS_NBANK];
    logic [3:0]              programmed_reg;
    logic [3:0]              released_reg;
    logic [2:0]              ctrl_reg;
    logic                    pwrdn_reg;
    logic                    serial_reg;
    logic [6:0]              addr_reg;
    logic                    pready_reg;
    logic                    pslverr_reg;
    logic [31:0]             prdata_reg;
    logic                    apb_done;
    logic                    apb_wr;
    logic                    addr_ok;
    logic                    pin_strap_lines;
    logic                    pd_request;
    logic [3:0]              pin_freq_live [CGMS_NBANK];
    logic [3:0]              pin_lvcmos_live;
    logic [3:0]              act_w;
    logic [3:0]              lvc_w;
    logic [3:0]              frq_w [CGMS_NBANK];
    logic [3:0]              code4a;
    logic [3:0]              code4b;
    logic [2:0]              bidx;

    // bank code from one tri-level pin; 11 is read as high
    function automatic logic [3:0] pin_code(input logic [1:0] lvl);
        pin_code = (lvl == CGMS_PIN_LOW) ? 4'h0 : (lvl == CGMS_PIN_MID) ? 4'h1 : 4'h2;
    endfunction

    // register index of a bank config word, 4 if not a bank word
    function automatic logic [2:0] bank_index(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - CGMS_BANK_CFG_OFS;
        if (a >= CGMS_BANK_CFG_OFS && a <= CGMS_ADDR_LAST && a[1:0] == 2'h0) begin
            bank_index = rel[4:2];
        end else begin
            bank_index = 3'h4;
        end
    endfunction

    // live pin decode; bank 4 is lvcmos when select a is low
    always_comb begin
        pin_freq_live[0] = pin_code(bank1_freq_select);
        pin_freq_live[1] = pin_code(bank2_freq_select);
        pin_freq_live[2] = pin_code(bank3_freq_select);
        code4a           = pin_code(output_bank_4_select_a);
        code4b           = pin_code(output_bank_4_select_b);
        pin_freq_live[3] = {code4a[1:0], code4b[1:0]};
        pin_lvcmos_live  = {(output_bank_4_select_a == CGMS_PIN_LOW), 3'h0};
    end

    // pin-strap needs both lines low, power-down needs data low
    assign pin_strap_lines = !serial_data_level && !serial_clock_powerdown;
    assign pd_request      = !serial_data_level && serial_clock_powerdown;

    // sequencer transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_LATCH: begin
                if (serial_data_level) begin
                    state_next = ST_MIX_WAIT;
                end else if (pd_request) begin
                    state_next = ST_PWRDN;
                end else begin
                    state_next = ST_PIN_WAIT;
                end
            end
            ST_PIN_WAIT, ST_PIN_RUN: begin
                if (pd_request) begin
                    state_next = ST_PWRDN;
                end else if (serial_data_level) begin
                    state_next = ST_MIX_WAIT;
                end else if (pll_locked) begin
                    state_next = ST_PIN_RUN;
                end
            end
            ST_PWRDN: begin
                if (!serial_clock_powerdown) begin
                    state_next = ST_LATCH;
                end
            end
            ST_MIX_WAIT: begin
                if (pll_locked) begin
                    state_next = ST_SERIAL;
                end
            end
            ST_SERIAL: begin
                state_next = ST_SERIAL;                       // lines are don't-care here
            end
            default: begin
                state_next = ST_LATCH;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_LATCH;
        end else begin
            state_reg <= state_next;
        end
    end

    // pin latch once at power-up; pin-strap keeps tracking, bus modes freeze it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < CGMS_NBANK; i++) begin
                pin_freq_reg[i] <= 4'h0;
            end
            pin_lvcmos_reg <= 4'h0;
        end else if (state_reg == ST_LATCH || state_reg == ST_PIN_RUN) begin
            for (int i = 0; i < CGMS_NBANK; i++) begin
                pin_freq_reg[i] <= pin_freq_live[i];
            end
            pin_lvcmos_reg <= pin_lvcmos_live;                // frozen outside latch and pin-strap run
        end
    end

    // release mask chosen once when the pll settles
    always_ff @(posedge clk) begin
        if (!rst_n || state_reg == ST_PWRDN || state_reg == ST_LATCH) begin
            released_reg <= 4'h0;                             // static until lock
        end else if (state_reg == ST_PIN_RUN) begin
            released_reg <= pin_strap_lines ? 4'hF : 4'h0;
        end else if (state_reg == ST_MIX_WAIT && pll_locked) begin
            if (!mixed_mode_select) begin
                released_reg <= 4'h0;
            end else if (output_bank_4_select_a == CGMS_PIN_LOW) begin
                released_reg <= 4'h8;
            end else begin
                released_reg <= 4'h7;
            end
        end else if (apb_wr && paddr == CGMS_CTRL_OFS && pwdata[CGMS_CTRL_LOADED_BIT]) begin
            released_reg <= 4'hF;
        end
    end

    // slave address from output_bank_4 pins when mixed select is low; mmc sampled at latch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_reg <= CGMS_SLAVE_BASE;
        end else if (state_reg == ST_LATCH) begin
            if (!mixed_mode_select) begin
                addr_reg <= {CGMS_SLAVE_BASE[6:4], pin_freq_live[3]};
            end else begin
                addr_reg <= CGMS_SLAVE_BASE;
            end
        end
    end

    // apb: registered pready gives one wait state per access
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= psel && penable && !pready_reg;
        end
    end

    // bank word index, shared by the read mux and the file writes
    assign bidx     = bank_index(paddr);
    assign apb_done = psel && penable && pready_reg;
    assign addr_ok  = (paddr == CGMS_CTRL_OFS) || (paddr == CGMS_STATUS_OFS)
                   || (bank_index(paddr) != 3'h4);
    // writes only land in serial-bus mode, no other path
    assign apb_wr   = apb_done && pwrite && serial_reg && addr_ok;

    // error on unmapped address or on a write outside serial-bus mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= psel && penable && !pready_reg && (!addr_ok || (pwrite && !serial_reg));
        end
    end

    // read mux
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && penable && !pready_reg && !pwrite) begin
            prdata_reg <= 32'h0000_0000;
            if (paddr == CGMS_CTRL_OFS) begin
                prdata_reg[2:0] <= ctrl_reg;
            end else if (paddr == CGMS_STATUS_OFS) begin
                prdata_reg[CGMS_ST_STATE_LSB +: 3] <= state_reg;
                prdata_reg[CGMS_ST_SERIAL_BIT]     <= serial_reg;
                prdata_reg[CGMS_ST_LOCK_BIT]       <= pll_locked;
                prdata_reg[CGMS_ST_ADDR_LSB +: 7]  <= addr_reg;
                prdata_reg[CGMS_ST_PROG_LSB +: 4]  <= programmed_reg;
                prdata_reg[CGMS_ST_REL_LSB +: 4]   <= released_reg;
            end else if (bank_index(paddr) != 3'h4) begin
                prdata_reg[CGMS_CFG_W-1:0] <= cfg_reg[bidx[1:0]];
            end
        end
    end

    // register files; pin power-down restarts as a power cycle and wipes them
    always_ff @(posedge clk) begin
        if (!rst_n || state_reg == ST_PWRDN) begin
            for (int i = 0; i < CGMS_NBANK; i++) begin
                cfg_reg[i] <= CGMS_CFG_RESET;
            end
            programmed_reg <= 4'h0;
            ctrl_reg       <= CGMS_CTRL_RESET;
        end else if (apb_wr) begin
            if (paddr == CGMS_CTRL_OFS) begin
                ctrl_reg <= pwdata[2:0];
            end else if (bank_index(paddr) != 3'h4) begin
                cfg_reg[bidx[1:0]]        <= pwdata[CGMS_CFG_W-1:0];
                programmed_reg[bidx[1:0]] <= 1'b1;
            end
        end
    end

    // serial-bus mode flag and device power-down
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_reg <= 1'b0;
            pwrdn_reg  <= 1'b0;
        end else begin
            serial_reg <= (state_next == ST_SERIAL);
            pwrdn_reg  <= (state_next == ST_PWRDN) || (state_reg == ST_SERIAL
                          && ctrl_reg[CGMS_CTRL_PWRDN_BIT]);
        end
    end

    // per-bank output select and release
    for (genvar g = 0; g < CGMS_NBANK; g++) begin : g_bank
        cgms_bank_out u_bank (
            .clk          (clk),
            .rst_n        (rst_n),
            .pin_freq     (pin_freq_reg[g]),
            .pin_lvcmos   (pin_lvcmos_reg[g]),
            .reg_cfg      (cfg_reg[g]),
            .programmed   (programmed_reg[g]),
            .released     (released_reg[g]),
            .pll_locked   (pll_locked),
            .powered_down (pwrdn_reg),
            .active_reg   (act_w[g]),
            .freq_reg     (frq_w[g]),
            .lvcmos_reg   (lvc_w[g])
        );
        assign bank_freq_code[4*g +: 4] = frq_w[g];
    end

    // bypass flop, so every output comes from a register
    logic bypass_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bypass_reg <= 1'b0;
        end else begin
            bypass_reg <= serial_reg && ctrl_reg[CGMS_CTRL_BYPASS_BIT];
        end
    end

    assign bank_active         = act_w;
    assign bank_lvcmos         = lvc_w;
    assign ref_bypass          = bypass_reg;
    assign device_powered_down = pwrdn_reg;
    assign serial_mode_active  = serial_reg;
    assign slave_address       = addr_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign prdata              = prdata_reg;

    // assertions
    property p_latch_static;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_LATCH |=> ##1 bank_active == 4'h0;
    endproperty
    a_latch_static: assert property (p_latch_static)
        else $error("banks active right after pin latch");

    property p_frozen_pins;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_SERIAL && $stable(state_reg) |=> $stable(pin_lvcmos_reg);
    endproperty
    a_frozen_pins: assert property (p_frozen_pins)
        else $error("pin latch changed in serial-bus mode");

    property p_mmc_low;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_MIX_WAIT && pll_locked && !mixed_mode_select |=> released_reg == 4'h0;
    endproperty
    a_mmc_low: assert property (p_mmc_low)
        else $error("bank released with mixed select low");

    property p_mmc_bank4;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_MIX_WAIT && pll_locked && mixed_mode_select
            && output_bank_4_select_a == CGMS_PIN_LOW |=> released_reg == 4'h8;
    endproperty
    a_mmc_bank4: assert property (p_mmc_bank4)
        else $error("wrong release mask for bank 4 only");

    property p_mmc_banks123;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_MIX_WAIT && pll_locked && mixed_mode_select
            && output_bank_4_select_a != CGMS_PIN_LOW |=> released_reg == 4'h7;
    endproperty
    a_mmc_banks123: assert property (p_mmc_banks123)
        else $error("wrong release mask for banks 1 to 3");

    property p_loaded_release;
        @(posedge clk) disable iff (!rst_n)
        apb_wr && paddr == CGMS_CTRL_OFS && pwdata[CGMS_CTRL_LOADED_BIT]
            |=> released_reg == 4'hF;
    endproperty
    a_loaded_release: assert property (p_loaded_release)
        else $error("loaded files did not release banks");

    property p_no_write_early;
        @(posedge clk) disable iff (!rst_n)
        psel && penable && pready && pwrite && !serial_mode_active |=> $stable(ctrl_reg);
    endproperty
    a_no_write_early: assert property (p_no_write_early)
        else $error("register written outside serial-bus mode");

    property p_pd_off;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_PIN_RUN && pd_request |=> device_powered_down ##1 bank_active == 4'h0;
    endproperty
    a_pd_off: assert property (p_pd_off)
        else $error("power-down pin did not switch outputs off");

    property p_serial_after_seq;
        @(posedge clk) disable iff (!rst_n)
        $rose(serial_mode_active) |-> $past(state_reg) == ST_MIX_WAIT;
    endproperty
    a_serial_after_seq: assert property (p_serial_after_seq)
        else $error("serial-bus mode entered outside mixed sequence");

    property p_pd_clears;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_PWRDN |=> programmed_reg == 4'h0;
    endproperty
    a_pd_clears: assert property (p_pd_clears)
        else $error("power-down did not clear register files");

endmodule
`default_nettype wire

// >>> verification/cgms_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// far side: sets the serial line levels and runs register transfers
module cgms_host_model (
    // clock
    input  wire logic        clk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    // serial line levels
    output logic             sda_level,
    output logic             pd_level
);
    logic [31:0] rd_data;
    logic        rd_err;
    // idle bus, lines low until a mode is chosen
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sda_level = 1'b0;
        pd_level = 1'b0;
    end
    // levels can change at any time, data high picks bus mode
    task automatic set_lines(input logic d, input logic p);
        sda_level <= d;
        pd_level <= p;
    endtask
    // one transfer; request held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verification/cgms_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cgms_sequencer_tb
    import cgms_pkg::*;
;
    logic clk, rst_n, mmc, pll, psel, penable, pwrite, sda, pd, pready, pslverr;
    logic        ref_bypass, powered_down, serial_on;
    logic [1:0]  b1, b2, b3, s4a, s4b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  bank_active, bank_lvcmos;
    logic [15:0] freq;
    logic [6:0]  slave_addr;
    int          fails, num_checks;
    int          cyc = 0;

    cgms_host_model cgms_host_model_inst (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sda_level(sda), .pd_level(pd));
    cgms_sequencer cgms_sequencer_inst (.clk(clk), .rst_n(rst_n), .serial_data_level(sda),
        .serial_clock_powerdown(pd), .mixed_mode_select(mmc), .bank1_freq_select(b1),
        .bank2_freq_select(b2), .bank3_freq_select(b3), .output_bank_4_select_a(s4a),
        .output_bank_4_select_b(s4b), .pll_locked(pll), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .bank_active(bank_active), .bank_freq_code(freq),
        .bank_lvcmos(bank_lvcmos), .ref_bypass(ref_bypass),
        .device_powered_down(powered_down), .serial_mode_active(serial_on),
        .slave_address(slave_addr));

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        if (fails == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // pins and lines are set during the reset pulse so the latch sees them
    task automatic powerup(input logic d, input logic p, input logic m, input logic [1:0] a,
                           input logic [1:0] bb, input logic lk);
        @(posedge clk);
        rst_n <= 1'b0;
        mmc <= m;
        s4a <= a;
        s4b <= bb;
        pll <= lk;
        b1 <= 2'h1;
        cgms_host_model_inst.set_lines(d, p);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cgms_host_model_inst.xfer(1'b1, a, d);
        repeat (3) @(posedge clk);
    endtask

    initial begin
        {rst_n, mmc, pll, b1, s4a, s4b, fails, num_checks} = '0;
        b2 = 2'h2;
        b3 = 2'h0;
        powerup(1'b1, 1'b0, 1'b1, 2'h0, 2'h1, 1'b0);
        chk(32'(bank_active), 32'h0);
        pll <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'(serial_on), 32'h1);
        chk(32'(bank_active), 32'h8);
        chk(32'(freq), 32'h1021);
        b1 <= 2'h2;
        s4a <= 2'h2;
        repeat (4) @(posedge clk);
        chk(32'({bank_active, freq}), 32'h81021);
        wr(CGMS_BANK_CFG_OFS, 32'h25);
        chk(32'(cgms_host_model_inst.rd_err), 32'h0);
        wr(CGMS_CTRL_OFS, 32'h1);
        chk(32'(bank_active), 32'hF);
        chk(32'(freq[7:0]), 32'h25);
        cgms_host_model_inst.xfer(1'b0, CGMS_STATUS_OFS, 32'h0);
        chk(32'(cgms_host_model_inst.rd_data[23:16]), 32'hF1);
        wr(CGMS_BANK_CFG_OFS, 32'h37);
        chk(32'({bank_lvcmos[0], freq[3:0]}), 32'h17);
        wr(CGMS_CTRL_OFS, 32'h3);
        chk(32'(ref_bypass), 32'h1);
        // enable clear and block power-down park bank 2 static
        wr(CGMS_BANK_CFG_OFS + 8'h04, 32'h42);
        chk(32'(bank_active), 32'hD);
        cgms_host_model_inst.xfer(1'b0, 8'h18, 32'h0);
        chk(32'(cgms_host_model_inst.rd_err), 32'h1);
        chk(cgms_host_model_inst.rd_data, 32'h0);
        pll <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(bank_active), 32'h0);
        // register power-down, only reachable in serial-bus mode
        wr(CGMS_CTRL_OFS, 32'h4);
        chk(32'(powered_down), 32'h1);
        powerup(1'b1, 1'b0, 1'b1, 2'h1, 2'h1, 1'b1);
        chk(32'({bank_active, freq[3:0]}), 32'h71);
        powerup(1'b1, 1'b0, 1'b0, 2'h2, 2'h0, 1'b1);
        chk(32'({bank_active, 1'b0, slave_addr}), 32'h068);
        powerup(1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 1'b1);
        chk(32'(bank_active), 32'hF);
        cgms_host_model_inst.xfer(1'b1, CGMS_CTRL_OFS, 32'h4);
        chk(32'(cgms_host_model_inst.rd_err), 32'h1);
        cgms_host_model_inst.set_lines(1'b0, 1'b1);
        repeat (4) @(posedge clk);
        chk(32'({powered_down, bank_active}), 32'h10);
        cgms_host_model_inst.set_lines(1'b0, 1'b0);
        repeat (8) @(posedge clk);
        chk(32'({powered_down, bank_active}), 32'h0F);
        // data high leaves pin-strap for the mixed sequence
        cgms_host_model_inst.set_lines(1'b1, 1'b0);
        repeat (4) @(posedge clk);
        chk(32'({serial_on, bank_active}), 32'h18);
        give_verdict();
    end
endmodule
`default_nettype wire
